// File: design/ptpl_pkg.sv
// Purpose: constants and types for the pulse train position loop
// Assumes: 16-bit parameter registers on a plain strobe port
// Notes: gains and levels are in tenths, as programmed
package ptpl_pkg;
    localparam logic [3:0] PTPL_A_MODE = 4'h0;
    localparam logic [3:0] PTPL_A_FMT = 4'h1;
    localparam logic [3:0] PTPL_A_GAIN1 = 4'h2;
    localparam logic [3:0] PTPL_A_GAIN2 = 4'h3;
    localparam logic [3:0] PTPL_A_GSW = 4'h4;
    localparam logic [3:0] PTPL_A_TLVL = 4'h5;
    localparam logic [3:0] PTPL_A_SLVL = 4'h6;
    localparam logic [3:0] PTPL_A_SMOOTH = 4'h7;
    localparam logic [3:0] PTPL_A_LIMIT = 4'h8;
    localparam logic [3:0] PTPL_A_WINDOW = 4'h9;
    localparam logic [3:0] PTPL_A_DTIME = 4'ha;
    localparam logic [3:0] PTPL_A_TARGET = 4'hb;
    localparam logic [3:0] PTPL_A_POSLO = 4'hc;
    localparam logic [3:0] PTPL_A_POSHI = 4'hd;
    localparam logic [3:0] PTPL_A_STATUS = 4'he;
    localparam logic [15:0] PTPL_RST_MODE = 16'h0000;
    localparam logic [15:0] PTPL_RST_FMT = 16'h0000;
    localparam logic [15:0] PTPL_RST_GAIN1 = 16'h00c8;
    localparam logic [15:0] PTPL_RST_GAIN2 = 16'h012c;
    localparam logic [15:0] PTPL_RST_GSW = 16'h0000;
    localparam logic [15:0] PTPL_RST_TLVL = 16'h0064;
    localparam logic [15:0] PTPL_RST_SLVL = 16'h0064;
    localparam logic [15:0] PTPL_RST_SMOOTH = 16'h0005;
    localparam logic [15:0] PTPL_RST_LIMIT = 16'h00c8;
    localparam logic [15:0] PTPL_RST_WINDOW = 16'h000a;
    localparam logic [15:0] PTPL_RST_DTIME = 16'h0064;
    localparam logic [15:0] PTPL_GAIN_MAX = 16'h0fa0;
    localparam logic [15:0] PTPL_PCT_MAX = 16'h03e8;
    localparam logic [15:0] PTPL_DTIME_MAX = 16'h2710;
    localparam logic [3:0] PTPL_SMOOTH_MAX = 4'hf;
    localparam logic [5:0] PTPL_PSI_FUNC = 6'h2b;
    localparam int PTPL_CLK_HZ = 50000000;
    localparam int PTPL_TICK_US = 100;
    localparam int PTPL_TICK_CYC = PTPL_CLK_HZ / 1000000 * PTPL_TICK_US;
    localparam logic [12:0] PTPL_TICK_LAST = 13'(PTPL_TICK_CYC - 1);
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ptpl_bus_t;
    typedef struct packed {
        logic [15:0] mode;
        logic [15:0] fmt;
        logic [15:0] gain1;
        logic [15:0] gain2;
        logic [15:0] gsw;
        logic [15:0] tlvl;
        logic [15:0] slvl;
        logic [15:0] smooth;
        logic [15:0] limit;
        logic [15:0] window;
        logic [15:0] dtime;
        logic [15:0] target;
    } ptpl_regs_t;
endpackage : ptpl_pkg

// File: design/ptpl_top.sv
// Purpose: pulse train decoder, gain selection, clamp and completion flag
// Assumes: inputs synchronous to sys_clk; deviation from the loop core
// Notes: loop arithmetic uses the programmed tenths directly
`timescale 1ns/1ps
`default_nettype none
module ptpl_top (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire ptpl_pkg::ptpl_bus_t bus,
    output logic [15:0] rdata,
    input wire logic pulse_input_a,
    input wire logic pulse_input_b,
    input wire logic closed_loop_vector_control,
    input wire logic [5:0] photo_term_func,
    input wire logic photo_term_in,
    input wire logic servo_enable,
    input wire logic run_fwd,
    input wire logic run_rev,
    input wire logic spindle_orient,
    input wire logic orient_moving,
    input wire logic [15:0] torque_cmd,
    input wire logic [15:0] speed_cmd,
    input wire logic [31:0] pos_deviation,
    input wire logic [31:0] regulator_raw,
    output logic position_control,
    output logic [1:0] command_source,
    output logic servo_on,
    output logic stop_move_start,
    output logic filter_average,
    output logic overspeed_ctl,
    output logic [15:0] active_gain,
    output logic [31:0] regulator_out,
    output logic regulator_active,
    output logic positioning_done,
    output logic [31:0] pulse_count
);
    import ptpl_pkg::*;

    typedef struct packed {
        logic [1:0] rst_sync;
        ptpl_regs_t regs;
        logic [15:0] rdata;
        logic a_q;
        logic b_q;
        logic photo_q;
        logic [31:0] count;
        logic [15:0] gain;
        logic [12:0] tick_cnt;
        logic [15:0] dwell;
        logic done;
        logic pos_ctl;
        logic [1:0] src;
        logic servo;
        logic stop_start;
        logic favg;
        logic ovs;
        logic [31:0] reg_out;
        logic reg_act;
    } ptpl_state_t;

    ptpl_state_t st_ff;
    ptpl_state_t nxt_st;
    logic rst_n;
    assign rst_n = st_ff.rst_sync[1];

    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] hi);
        clamp16 = (v > hi) ? hi : v;
    endfunction : clamp16

    function automatic logic [31:0] abs32(input logic [31:0] v);
        abs32 = v[31] ? (32'h0 - v) : v;
    endfunction : abs32

    logic a_rise, b_rise, a_chg, b_chg, dir_rev, run_dir_rev;
    logic signed [1:0] step;
    logic [15:0] gain_target;
    logic high_level;
    logic [31:0] lim_abs, raw_abs;
    logic [31:0] gain_diff;

    always_comb begin
        a_chg = pulse_input_a != st_ff.a_q;
        b_chg = pulse_input_b != st_ff.b_q;
        a_rise = pulse_input_a & ~st_ff.a_q;
        b_rise = pulse_input_b & ~st_ff.b_q;
        step = 2'sd0;
        case (st_ff.regs.fmt[3:0])
            4'h0: begin
                // quadrature: one channel moves per step; both at once is noise
                if (a_chg && !b_chg) begin
                    step = (pulse_input_a != pulse_input_b) ? 2'sd1 : -2'sd1;
                end else if (b_chg && !a_chg) begin
                    step = (pulse_input_a == pulse_input_b) ? 2'sd1 : -2'sd1;
                end
            end
            4'h1: begin
                if (a_rise) begin
                    step = pulse_input_b ? -2'sd1 : 2'sd1;
                end
            end
            4'h2: begin
                if (a_rise) begin
                    step = 2'sd1;
                end
            end
            4'h3: begin
                if (a_rise && !b_rise) begin
                    step = 2'sd1;
                end else if (b_rise && !a_rise) begin
                    step = -2'sd1;
                end
            end
            default: step = 2'sd0;
        endcase
        run_dir_rev = run_rev & ~run_fwd;
        dir_rev = st_ff.regs.fmt[5] ? run_dir_rev : st_ff.regs.fmt[4];
        if (dir_rev) begin
            step = -step;
        end
        case (st_ff.regs.gsw[2:0])
            3'h1: high_level = torque_cmd > st_ff.regs.tlvl;
            3'h2: high_level = speed_cmd > st_ff.regs.slvl;
            default: high_level = 1'b0; // reserved codes behave as no switch
        endcase
        if (spindle_orient) begin
            gain_target = orient_moving ? st_ff.regs.gain2 : st_ff.regs.gain1;
        end else begin
            gain_target = high_level ? st_ff.regs.gain2 : st_ff.regs.gain1;
        end
        lim_abs = 32'(st_ff.regs.limit);
        raw_abs = abs32(regulator_raw);
        gain_diff = {16'h0, gain_target} - {16'h0, st_ff.gain};
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rst_sync = {st_ff.rst_sync[0], 1'b1};
        nxt_st.a_q = pulse_input_a;
        nxt_st.b_q = pulse_input_b;
        nxt_st.photo_q = photo_term_in;
        nxt_st.rdata = 16'h0000;
        if (bus.wr) begin
            case (bus.addr)
                PTPL_A_MODE: nxt_st.regs.mode = bus.wdata;
                PTPL_A_FMT: nxt_st.regs.fmt = bus.wdata;
                PTPL_A_GAIN1: nxt_st.regs.gain1 = clamp16(bus.wdata, PTPL_GAIN_MAX);
                PTPL_A_GAIN2: nxt_st.regs.gain2 = clamp16(bus.wdata, PTPL_GAIN_MAX);
                PTPL_A_GSW: nxt_st.regs.gsw = bus.wdata;
                PTPL_A_TLVL: nxt_st.regs.tlvl = clamp16(bus.wdata, PTPL_PCT_MAX);
                PTPL_A_SLVL: nxt_st.regs.slvl = clamp16(bus.wdata, PTPL_PCT_MAX);
                PTPL_A_SMOOTH: nxt_st.regs.smooth = {12'h000, bus.wdata[3:0]};
                PTPL_A_LIMIT: nxt_st.regs.limit = clamp16(bus.wdata, PTPL_PCT_MAX);
                PTPL_A_WINDOW: nxt_st.regs.window = bus.wdata;
                PTPL_A_DTIME: nxt_st.regs.dtime = clamp16(bus.wdata, PTPL_DTIME_MAX);
                PTPL_A_TARGET: nxt_st.regs.target = bus.wdata;
                default: ;
            endcase
        end
        if (bus.rd) begin
            case (bus.addr)
                PTPL_A_MODE: nxt_st.rdata = st_ff.regs.mode;
                PTPL_A_FMT: nxt_st.rdata = st_ff.regs.fmt;
                PTPL_A_GAIN1: nxt_st.rdata = st_ff.regs.gain1;
                PTPL_A_GAIN2: nxt_st.rdata = st_ff.regs.gain2;
                PTPL_A_GSW: nxt_st.rdata = st_ff.regs.gsw;
                PTPL_A_TLVL: nxt_st.rdata = st_ff.regs.tlvl;
                PTPL_A_SLVL: nxt_st.rdata = st_ff.regs.slvl;
                PTPL_A_SMOOTH: nxt_st.rdata = st_ff.regs.smooth;
                PTPL_A_LIMIT: nxt_st.rdata = st_ff.regs.limit;
                PTPL_A_WINDOW: nxt_st.rdata = st_ff.regs.window;
                PTPL_A_DTIME: nxt_st.rdata = st_ff.regs.dtime;
                PTPL_A_TARGET: nxt_st.rdata = st_ff.regs.target;
                PTPL_A_POSLO: nxt_st.rdata = st_ff.count[15:0];
                PTPL_A_POSHI: nxt_st.rdata = st_ff.count[31:16];
                PTPL_A_STATUS: nxt_st.rdata = {9'h000, st_ff.reg_act, st_ff.servo, st_ff.done,
                    st_ff.src, st_ff.pos_ctl, st_ff.ovs};
                default: nxt_st.rdata = 16'h0000; // unmapped reads zero
            endcase
        end
        // count only from the pulse source; other sources hold the count
        if (st_ff.src == 2'd0) begin
            nxt_st.count = st_ff.count + 32'(signed'(step));
        end
        nxt_st.pos_ctl = closed_loop_vector_control && (st_ff.regs.mode[3:0] == 4'h1);
        nxt_st.src = (st_ff.regs.mode[7:4] > 4'h2) ? 2'd0 : st_ff.regs.mode[5:4];
        nxt_st.stop_start = st_ff.pos_ctl && (st_ff.src == 2'd2)
            && (photo_term_func == PTPL_PSI_FUNC) && photo_term_in && !st_ff.photo_q;
        // servo holds once on; cleared when position control drops
        if (!st_ff.pos_ctl) begin
            nxt_st.servo = 1'b0;
        end else if (st_ff.src == 2'd0 || spindle_orient) begin
            nxt_st.servo = servo_enable || run_fwd || run_rev || st_ff.servo;
        end else begin
            nxt_st.servo = 1'b1;
        end
        nxt_st.favg = st_ff.regs.fmt[12];
        nxt_st.ovs = st_ff.regs.fmt[13];
        // smoothing: move by diff >> coefficient, at least one step
        if (gain_diff != 32'h0) begin
            if (gain_diff[31]) begin
                nxt_st.gain = st_ff.gain - 16'(((32'h0 - gain_diff) >> st_ff.regs.smooth[3:0])
                    | 32'h1);
            end else begin
                nxt_st.gain = st_ff.gain + 16'((gain_diff >> st_ff.regs.smooth[3:0])
                    | 32'h1);
            end
        end
        nxt_st.reg_act = st_ff.pos_ctl && (st_ff.regs.limit != 16'h0);
        if (!nxt_st.reg_act) begin
            nxt_st.reg_out = 32'h0;
        end else if (raw_abs > lim_abs) begin
            nxt_st.reg_out = regulator_raw[31] ? (32'h0 - lim_abs) : lim_abs;
        end else begin
            nxt_st.reg_out = regulator_raw;
        end
        // dwell counts 0.1 ms ticks while inside the window
        nxt_st.tick_cnt = (st_ff.tick_cnt == PTPL_TICK_LAST) ? 13'h0 : st_ff.tick_cnt + 13'h1;
        if (abs32(pos_deviation) >= 32'(st_ff.regs.window) || !st_ff.pos_ctl) begin
            nxt_st.dwell = 16'h0;
            nxt_st.done = 1'b0;
            nxt_st.tick_cnt = 13'h0;
        end else begin
            if (st_ff.tick_cnt == PTPL_TICK_LAST && st_ff.dwell != 16'hffff) begin
                nxt_st.dwell = st_ff.dwell + 16'h1;
            end
            nxt_st.done = st_ff.dwell > st_ff.regs.dtime;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
            st_ff.regs.mode <= PTPL_RST_MODE;
            st_ff.regs.fmt <= PTPL_RST_FMT;
            st_ff.regs.gain1 <= PTPL_RST_GAIN1;
            st_ff.regs.gain2 <= PTPL_RST_GAIN2;
            st_ff.regs.gsw <= PTPL_RST_GSW;
            st_ff.regs.tlvl <= PTPL_RST_TLVL;
            st_ff.regs.slvl <= PTPL_RST_SLVL;
            st_ff.regs.smooth <= PTPL_RST_SMOOTH;
            st_ff.regs.limit <= PTPL_RST_LIMIT;
            st_ff.regs.window <= PTPL_RST_WINDOW;
            st_ff.regs.dtime <= PTPL_RST_DTIME;
            st_ff.gain <= PTPL_RST_GAIN1;
        end else if (!rst_n) begin
            st_ff.rst_sync <= nxt_st.rst_sync;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata = st_ff.rdata;
    assign position_control = st_ff.pos_ctl;
    assign command_source = st_ff.src;
    assign servo_on = st_ff.servo;
    assign stop_move_start = st_ff.stop_start;
    assign filter_average = st_ff.favg;
    assign overspeed_ctl = st_ff.ovs;
    assign active_gain = st_ff.gain;
    assign regulator_out = st_ff.reg_out;
    assign regulator_active = st_ff.reg_act;
    assign positioning_done = st_ff.done;
    assign pulse_count = st_ff.count;
endmodule : ptpl_top
`default_nettype wire

// File: testbench/ptpl_asserts.sv
// Purpose: port-level checks for the pulse train position loop
// Assumes: bound to ptpl_top, single sys_clk domain
// Notes: windows are generous where latency is the designer's choice
`timescale 1ns/1ps
`default_nettype none
module ptpl_asserts (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic closed_loop_vector_control,
    input wire logic [5:0] photo_term_func,
    input wire logic position_control,
    input wire logic [1:0] command_source,
    input wire logic stop_move_start,
    input wire logic [15:0] active_gain,
    input wire logic [31:0] regulator_out,
    input wire logic regulator_active,
    input wire logic positioning_done,
    input wire logic pulse_input_a,
    input wire logic pulse_input_b,
    input wire logic [31:0] pulse_count
);
    import ptpl_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    a_pos_needs_vc: assert property (!closed_loop_vector_control [*2] |=> !position_control)
        else $error("position control without vector control");
    a_src_legal: assert property (command_source != 2'h3)
        else $error("command source out of range");
    a_stop_single: assert property (stop_move_start |=> !stop_move_start)
        else $error("stop move start longer than one cycle");
    a_stop_cause: assert property (stop_move_start |-> command_source == 2'h2
        && photo_term_func == PTPL_PSI_FUNC)
        else $error("stop move without armed photo terminal");
    a_gain_max: assert property (active_gain <= PTPL_GAIN_MAX)
        else $error("active gain above range");
    a_reg_off_zero: assert property (!regulator_active |-> regulator_out == 32'h0)
        else $error("regulator output while inactive");
    a_reg_clamp: assert property ($signed(regulator_out) <= 32'sd1000
        && $signed(regulator_out) >= -32'sd1000)
        else $error("regulator output beyond full scale");
    a_done_needs_pos: assert property (!position_control [*3] |=> !positioning_done)
        else $error("positioning done outside position control");
    a_count_quiet: assert property (($stable(pulse_input_a) && $stable(pulse_input_b)) [*4]
        |=> $stable(pulse_count))
        else $error("count moved with idle channels");
    a_count_step: assert property ($changed(pulse_count) |-> pulse_count - $past(pulse_count)
        == 32'h1 || $past(pulse_count) - pulse_count == 32'h1)
        else $error("count stepped by more than one");
endmodule : ptpl_asserts
bind ptpl_top ptpl_asserts u_chk (.sys_clk, .arst_n, .closed_loop_vector_control,
    .photo_term_func, .position_control, .command_source, .stop_move_start, .active_gain,
    .regulator_out, .regulator_active, .positioning_done, .pulse_input_a, .pulse_input_b,
    .pulse_count);
`default_nettype wire

// File: testbench/ptpl_pulse_src.sv
// Purpose: upstream controller model driving the two pulse channels
// Assumes: one level change per gap cycles, after a rising edge
// Notes: pattern 4 moves both lines at once on purpose
`timescale 1ns/1ps
`default_nettype none
module ptpl_pulse_src (
    input wire logic sys_clk,
    output logic pulse_input_a,
    output logic pulse_input_b
);
    initial begin
        pulse_input_a = 1'b0;
        pulse_input_b = 1'b0;
    end
    task automatic step(input logic a, input logic b, input int gap);
        repeat (gap) @(posedge sys_clk);
        pulse_input_a <= a;
        pulse_input_b <= b;
    endtask : step
    // every send ends with 00 so a quadrature move never starts on a double change
    task automatic send(input int md, input int n, input bit rev, input int gap);
        for (int i = 0; i < n; i++) begin
            case (md)
                0: begin
                    step(!rev, rev, gap);
                    step(1'b1, 1'b1, gap);
                    step(rev, !rev, gap);
                    step(1'b0, 1'b0, gap);
                end
                1: begin
                    step(1'b0, rev, gap);
                    step(1'b1, rev, gap);
                    step(1'b0, rev, gap);
                end
                3: begin
                    step(!rev, rev, gap);
                    step(1'b0, 1'b0, gap);
                end
                default: begin
                    step(1'b1, 1'b1, gap);
                    step(1'b0, 1'b0, gap);
                end
            endcase
        end
        step(1'b0, 1'b0, gap);
    endtask : send
endmodule : ptpl_pulse_src
`default_nettype wire

// File: testbench/pulse_train_position_loop_tb.sv
// Purpose: self-checking bench for the pulse train position loop
// Assumes: outputs sampled at the edge, before that edge's updates, except rd, which reads rdata 1 ns after the edge
// Notes: completion dwell uses a 0.1 ms detection time to keep the run short
`timescale 1ns/1ps
`default_nettype none
module pulse_train_position_loop_tb;
    import ptpl_pkg::*;
    typedef struct { logic [15:0] fmt; int pat; int n; bit rev; logic rr; int d; } ptpl_row_t;
    typedef struct { logic [15:0] gs; logic [15:0] tq; logic [15:0] sp; logic so; logic mv;
        logic [15:0] g; } ptpl_grow_t;
    logic sys_clk = 1'b0, arst_n = 1'b0, closed_loop_vector_control = 1'b1;
    logic photo_term_in = 1'b0, servo_enable = 1'b0, run_fwd = 1'b0, run_rev = 1'b0;
    logic spindle_orient = 1'b0, orient_moving = 1'b0;
    logic [5:0] photo_term_func = 6'h00;
    logic [15:0] torque_cmd = 16'h0000, speed_cmd = 16'h0000, rdata, d;
    logic [31:0] pos_deviation = 32'h0, regulator_raw = 32'h0, regulator_out, pulse_count;
    logic pulse_input_a, pulse_input_b, position_control, servo_on, stop_move_start;
    logic filter_average, overspeed_ctl, regulator_active, positioning_done;
    logic [1:0] command_source;
    logic [15:0] active_gain;
    ptpl_bus_t bus = '0;
    int error_cnt = 0, total_checks = 0, cyc_cnt = 0, exp_cnt = 0;
    ptpl_row_t rows[10] = '{'{16'h0000, 0, 2, 0, 0, 8}, '{16'h0000, 0, 2, 1, 0, -8},
        '{16'h1001, 1, 3, 0, 0, 3}, '{16'h2001, 1, 3, 1, 0, -3}, '{16'h0002, 2, 4, 0, 0, 4},
        '{16'h0003, 3, 2, 0, 0, 2}, '{16'h0003, 3, 5, 1, 0, -5}, '{16'h0010, 0, 1, 0, 0, -4},
        '{16'h0020, 0, 1, 0, 1, -4}, '{16'h0000, 4, 3, 0, 0, 0}};
    ptpl_grow_t grows[8] = '{'{0, 500, 500, 0, 0, 200}, '{1, 500, 0, 0, 0, 300},
        '{1, 50, 0, 0, 0, 200}, '{2, 0, 500, 0, 0, 300}, '{2, 500, 50, 0, 0, 200},
        '{3, 500, 500, 0, 0, 200}, '{0, 0, 0, 1, 1, 300}, '{1, 500, 0, 1, 0, 200}};
    logic [15:0] rstv[11] = '{PTPL_RST_MODE, PTPL_RST_FMT, PTPL_RST_GAIN1, PTPL_RST_GAIN2,
        PTPL_RST_GSW, PTPL_RST_TLVL, PTPL_RST_SLVL, PTPL_RST_SMOOTH, PTPL_RST_LIMIT,
        PTPL_RST_WINDOW, PTPL_RST_DTIME};
    ptpl_top dut (.sys_clk, .arst_n, .bus, .rdata, .pulse_input_a, .pulse_input_b,
        .closed_loop_vector_control, .photo_term_func, .photo_term_in, .servo_enable, .run_fwd,
        .run_rev, .spindle_orient, .orient_moving, .torque_cmd, .speed_cmd, .pos_deviation,
        .regulator_raw, .position_control, .command_source, .servo_on, .stop_move_start,
        .filter_average, .overspeed_ctl, .active_gain, .regulator_out, .regulator_active,
        .positioning_done, .pulse_count);
    ptpl_pulse_src src (.sys_clk, .pulse_input_a, .pulse_input_b);
    always #10 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc
    // one idle cycle after each strobe, so no task re-drives bus in the same step
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        bus <= '{a, v, 1'b1, 1'b0};
        cyc(1);
        bus <= '0;
        cyc(1);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        bus <= '{a, 16'h0000, 1'b0, 1'b1};
        cyc(1);
        bus <= '0;
        #1;
        v = rdata;
        cyc(1);
    endtask : rd
    task automatic do_reset();
        arst_n <= 1'b0;
        cyc(8);
        chk(32'(active_gain), 32'h00c8);
        chk(pulse_count, 32'h0);
        arst_n <= 1'b1;
        cyc(3);
    endtask : do_reset
    task automatic photo(input logic [5:0] f, input int exp);
        int hits = 0;
        photo_term_func <= f;
        cyc(2);
        photo_term_in <= 1'b1;
        repeat (10) begin
            cyc(1);
            hits += int'(stop_move_start);
        end
        photo_term_in <= 1'b0;
        chk(32'(hits), 32'(exp));
    endtask : photo
    task automatic gwait(input logic [15:0] g);
        for (int k = 0; k < 400 && active_gain !== g; k++) cyc(1);
        chk(32'(active_gain), 32'(g));
    endtask : gwait
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up
    // ceiling covers the dwell wait with room to spare
    always @(posedge sys_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 60000) begin
            error_cnt++;
            wrap_up();
        end
    end
    initial begin
        @(posedge sys_clk);
        foreach (rows[i]) begin
            do_reset();
            break;
        end
        for (int a = 0; a < 11; a++) begin
            rd(4'(a), d);
            chk(32'(d), 32'(rstv[a]));
        end
        wr(4'hf, 16'h1234);
        rd(4'hf, d);
        chk(32'(d), 32'h0);
        wr(PTPL_A_POSLO, 16'h1234);
        rd(PTPL_A_POSLO, d);
        chk(32'(d), 32'h0);
        wr(PTPL_A_MODE, 16'h0001);
        cyc(3);
        chk(32'(servo_on), 32'h0);
        run_fwd <= 1'b1;
        cyc(3);
        chk(32'(servo_on), 32'h1);
        run_fwd <= 1'b0;
        do_reset();
        wr(PTPL_A_MODE, 16'h0001);
        servo_enable <= 1'b1;
        cyc(3);
        chk(32'(servo_on), 32'h1);
        foreach (rows[i]) begin
            wr(PTPL_A_FMT, rows[i].fmt);
            run_rev <= rows[i].rr;
            src.send(rows[i].pat, rows[i].n, rows[i].rev, i % 2 + 1);
            cyc(4);
            exp_cnt += rows[i].d;
            chk(pulse_count, 32'(exp_cnt));
            chk(32'(filter_average), 32'(rows[i].fmt[12]));
            chk(32'(overspeed_ctl), 32'(rows[i].fmt[13]));
        end
        rd(PTPL_A_POSLO, d);
        chk(32'(d), 32'(exp_cnt[15:0]));
        for (int m = 0; m < 3; m++) begin
            wr(PTPL_A_MODE, 16'(m * 16 + 1));
            cyc(2);
            chk(32'(command_source), 32'(m));
            chk(32'(position_control), 32'h1);
        end
        photo(PTPL_PSI_FUNC, 1);
        photo(6'h2a, 0);
        closed_loop_vector_control <= 1'b0;
        cyc(3);
        chk(32'(position_control), 32'h0);
        closed_loop_vector_control <= 1'b1;
        wr(PTPL_A_MODE, 16'h0000);
        cyc(2);
        chk(32'(position_control), 32'h0);
        wr(PTPL_A_MODE, 16'h0001);
        foreach (grows[i]) begin
            wr(PTPL_A_GSW, grows[i].gs);
            torque_cmd <= grows[i].tq;
            speed_cmd <= grows[i].sp;
            spindle_orient <= grows[i].so;
            orient_moving <= grows[i].mv;
            gwait(grows[i].g);
        end
        regulator_raw <= 32'd500;
        cyc(3);
        chk(regulator_out, 32'd200);
        regulator_raw <= -32'sd500;
        cyc(3);
        chk(regulator_out, 32'hffffff38);
        wr(PTPL_A_LIMIT, 16'h0000);
        cyc(3);
        chk(32'(regulator_active), 32'h0);
        chk(regulator_out, 32'h0);
        wr(PTPL_A_DTIME, 16'h0001);
        pos_deviation <= 32'd5;
        cyc(4000);
        chk(32'(positioning_done), 32'h0);
        for (int k = 0; k < 16000 && positioning_done !== 1'b1; k++) cyc(1);
        chk(32'(positioning_done), 32'h1);
        pos_deviation <= 32'd10;
        cyc(4);
        chk(32'(positioning_done), 32'h0);
        wrap_up();
    end
endmodule : pulse_train_position_loop_tb
`default_nettype wire
